// ===== src/sfr_address_decode.sv
`timescale 1ns/1ps
// =====================================================
// Register index to storage slot decoder
module sfr_address_decode #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Access
  input  wire logic [11:0] index,
  input  wire logic        map_select,
  input  wire logic [1:0]  mask_mode,
  // Result
  output logic             slot_hit,
  output logic [4:0]       slot,
  output logic             wdt_hit
);

  logic       shared;
  logic [4:0] pair;

  // Shared pair lookup, select picks default or alternate
  always_comb begin
    shared = 1'b1;
    pair   = 5'h00;
    case (index)
      sfr_select_pkg::IDX_OSC_CTRL:  pair = 5'h00;
      sfr_select_pkg::IDX_T1_HIGH:   pair = 5'h01;
      sfr_select_pkg::IDX_T1_LOW:    pair = 5'h02;
      sfr_select_pkg::IDX_T1_CTRL:   pair = 5'h03;
      sfr_select_pkg::IDX_T2_COUNT:  pair = 5'h04;
      sfr_select_pkg::IDX_T2_PERIOD: pair = 5'h05;
      sfr_select_pkg::IDX_CONV_0:    pair = 5'h06;
      sfr_select_pkg::IDX_CONV_1:    pair = 5'h07;
      sfr_select_pkg::IDX_T4_PERIOD: pair = 5'h08;
      default:                       shared = 1'b0;
    endcase
  end

  // Final slot, serial context pairs follow mask mode, parallel pairs share one slot
  always_comb begin
    slot_hit = 1'b1;
    slot     = 5'h00;
    wdt_hit  = (index == sfr_select_pkg::IDX_WDT_CTRL);
    if (shared) begin
      slot = map_select ? sfr_select_pkg::SLOT_ALT_BASE + pair : pair;
      if (map_select && pair == sfr_select_pkg::PAIR_MEM_IF && !LARGE_VARIANT) begin
        slot_hit = 1'b0;
      end
    end else begin
      case (index)
        sfr_select_pkg::IDX_SSP1_ADDR:
          slot = mask_mode[0] ? sfr_select_pkg::SLOT_SSP1_MSK : sfr_select_pkg::SLOT_SSP1_ADR;
        sfr_select_pkg::IDX_SSP2_ADDR:
          slot = mask_mode[1] ? sfr_select_pkg::SLOT_SSP2_MSK : sfr_select_pkg::SLOT_SSP2_ADR;
        sfr_select_pkg::IDX_PAR_ADR_H, sfr_select_pkg::IDX_PAR_OUT_H:
          slot = sfr_select_pkg::SLOT_PAR_HIGH;
        sfr_select_pkg::IDX_PAR_ADR_L, sfr_select_pkg::IDX_PAR_OUT_L:
          slot = sfr_select_pkg::SLOT_PAR_LOW;
        default:
          slot_hit = 1'b0;
      endcase
    end
  end

endmodule

// ===== src/sfr_register_store.sv
`timescale 1ns/1ps
// =====================================================
// Byte storage behind the decoded slots
module sfr_register_store (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Write port
  input  wire logic       write_en,
  input  wire logic [4:0] write_slot,
  input  wire logic [7:0] write_data,
  // Read port
  input  wire logic [4:0] read_slot,
  output logic      [7:0] read_data,
  // Parallel port pair
  output logic      [15:0] par_pair
);

  logic [7:0] mem [sfr_select_pkg::SLOT_COUNT];

  // Storage update, one byte per write
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < sfr_select_pkg::SLOT_COUNT; i++) begin
        mem[i] <= sfr_select_pkg::REG_RESET;
      end
    end else if (write_en) begin
      mem[write_slot] <= write_data;
    end
  end

  // Read and pair taps
  assign read_data = mem[read_slot];
  assign par_pair  = {mem[sfr_select_pkg::SLOT_PAR_HIGH], mem[sfr_select_pkg::SLOT_PAR_LOW]};

endmodule

// ===== src/sfr_select_pkg.sv
// =====================================================
// Shared address register select constants
package sfr_select_pkg;

  // =====================================================
  // Bus geometry
  localparam int          ADDR_W    = 14;
  localparam int          INDEX_W   = 12;
  localparam int          SLOT_W    = 5;
  localparam int          SLOT_COUNT = 24;
  localparam logic [1:0]  RESP_OKAY = 2'h0;

  // =====================================================
  // Register indices, byte address is four times these
  localparam logic [11:0] IDX_WDT_CTRL  = 12'hFC0;
  localparam logic [11:0] IDX_OSC_CTRL  = 12'hFD3;
  localparam logic [11:0] IDX_T1_HIGH   = 12'hFCF;
  localparam logic [11:0] IDX_T1_LOW    = 12'hFCE;
  localparam logic [11:0] IDX_T1_CTRL   = 12'hFCD;
  localparam logic [11:0] IDX_T2_COUNT  = 12'hFCC;
  localparam logic [11:0] IDX_T2_PERIOD = 12'hFCB;
  localparam logic [11:0] IDX_CONV_0    = 12'hFC2;
  localparam logic [11:0] IDX_CONV_1    = 12'hFC1;
  localparam logic [11:0] IDX_T4_PERIOD = 12'hF77;
  localparam logic [11:0] IDX_SSP1_ADDR = 12'hFC8;
  localparam logic [11:0] IDX_SSP2_ADDR = 12'hF6E;
  localparam logic [11:0] IDX_PAR_ADR_H = 12'hF69;
  localparam logic [11:0] IDX_PAR_ADR_L = 12'hF68;
  localparam logic [11:0] IDX_PAR_OUT_H = 12'hF47;
  localparam logic [11:0] IDX_PAR_OUT_L = 12'hF46;

  // =====================================================
  // Watchdog and map control fields
  localparam int          BIT_REG_LP   = 7;
  localparam int          BIT_LV_STAT  = 6;
  localparam int          BIT_MAP_SEL  = 4;
  localparam int          BIT_SW_WDT   = 0;
  localparam logic        WDT_RESET    = 1'b0;
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // =====================================================
  // Storage slots: defaults, alternates, context pairs
  localparam logic [4:0]  SLOT_ALT_BASE = 5'h09;
  localparam logic [4:0]  PAIR_MEM_IF   = 5'h05;
  localparam logic [4:0]  SLOT_SSP1_ADR = 5'h12;
  localparam logic [4:0]  SLOT_SSP1_MSK = 5'h13;
  localparam logic [4:0]  SLOT_SSP2_ADR = 5'h14;
  localparam logic [4:0]  SLOT_SSP2_MSK = 5'h15;
  localparam logic [4:0]  SLOT_PAR_HIGH = 5'h16;
  localparam logic [4:0]  SLOT_PAR_LOW  = 5'h17;

endpackage

// ===== src/shared_address_sfr_select.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// =====================================================
// Functional notes
// - Some single addresses decode to one of two physical registers.
// - Control bit 4 selects alternate (1) or default (0) registers.
// - FD3h, FCFh, FCEh map oscillator and timer1 pairs to alternates.
// - FCDh, FCCh, FCBh map timer1 control and timer2 pairs.
// - FC2h, FC1h, F77h map converter and timer4 period pairs.
// - Alternate memory-interface control exists only in the large variant.
// - Select bit is read/write, resets 0, changes only by software write.
// - Serial slave address or mask is chosen by port mode.
// - Parallel address and output-data pairs are one physical register set.
// - Parallel pair acts as address in master, data in slave mode.
// - Control bits 5 and 3..1 read zero and ignore writes.
// - Control bit 6 is read-only core supply status.
// - Control bit 7 is regulator low-power enable, resets 0.
// - Control bit 0 is software watchdog enable, resets 0.
// - Unimplemented locations read as zero.
module shared_address_sfr_select #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Write address channel
  input  wire logic [13:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address channel
  input  wire logic [13:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Peripheral context
  input  wire logic [1:0]  serial_port_mask_mode,
  input  wire logic        parallel_port_master_mode,
  input  wire logic        core_supply_ok,
  // Control outputs
  output logic             shared_map_select,
  output logic             regulator_low_power_enable,
  output logic             software_watchdog_enable,
  output logic [15:0]      parallel_port_address,
  output logic [15:0]      parallel_port_output_data
);

  // =====================================================
  // Internal state
  logic [11:0] aw_index;
  logic [11:0] ar_index;
  logic        aw_held;
  logic        w_held;
  logic        ar_held;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        supply_meta;
  logic        low_voltage_status;
  logic        do_write;
  logic        do_read;
  logic [11:0] dec_index;
  logic        dec_hit;
  logic [4:0]  dec_slot;
  logic        dec_wdt;
  logic [7:0]  store_rdata;
  logic [15:0] par_pair;
  logic        store_we;
  logic        wdt_we;
  logic [7:0]  wdt_value;
  logic [7:0]  next_read_byte;

  // =====================================================
  // Access sequencing, write wins a tie
  assign do_write  = aw_held && w_held && !bvalid;
  assign do_read   = ar_held && !rvalid && !do_write;
  assign dec_index = do_write ? aw_index : ar_index;
  assign store_we  = do_write && w_lane0 && dec_hit;
  assign wdt_we    = do_write && w_lane0 && dec_wdt;

  // Address decoder shared by read and write
  sfr_address_decode #(
    .LARGE_VARIANT (LARGE_VARIANT)
  ) u_decode (
    .index      (dec_index),
    .map_select (shared_map_select),
    .mask_mode  (serial_port_mask_mode),
    .slot_hit   (dec_hit),
    .slot       (dec_slot),
    .wdt_hit    (dec_wdt)
  );

  // Register storage
  sfr_register_store u_store (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .write_en   (store_we),
    .write_slot (dec_slot),
    .write_data (w_byte),
    .read_slot  (dec_slot),
    .read_data  (store_rdata),
    .par_pair   (par_pair)
  );

  // =====================================================
  // Write address and data capture
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      awready  <= 1'b1;
      aw_held  <= 1'b0;
      aw_index <= 12'h000;
    end else if (awvalid && awready) begin
      awready  <= 1'b0;
      aw_held  <= 1'b1;
      aw_index <= awaddr[13:2];
    end else if (bvalid && bready) begin
      awready  <= 1'b1;
      aw_held  <= 1'b0;
    end
  end

  // Write data holds until the response is taken
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wready  <= 1'b1;
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      wready  <= 1'b0;
      w_held  <= 1'b1;
      w_byte  <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (bvalid && bready) begin
      wready  <= 1'b1;
      w_held  <= 1'b0;
    end
  end

  // Write response, always OKAY
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= sfr_select_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= sfr_select_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // =====================================================
  // Read address capture
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      arready  <= 1'b1;
      ar_held  <= 1'b0;
      ar_index <= 12'h000;
    end else if (arvalid && arready) begin
      arready  <= 1'b0;
      ar_held  <= 1'b1;
      ar_index <= araddr[13:2];
    end else if (do_read) begin
      ar_held  <= 1'b0;
    end else if (rvalid && rready) begin
      arready  <= 1'b1;
    end
  end

  // Read byte selection
  always_comb begin
    next_read_byte = 8'h00;
    if (dec_wdt) begin
      next_read_byte = wdt_value;
    end else if (dec_hit) begin
      next_read_byte = store_rdata;
    end
  end

  // Read data, upper bytes zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= sfr_select_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, next_read_byte};
      rresp  <= sfr_select_pkg::RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // =====================================================
  // Watchdog and map control register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shared_map_select          <= sfr_select_pkg::WDT_RESET;
      regulator_low_power_enable <= sfr_select_pkg::WDT_RESET;
      software_watchdog_enable   <= sfr_select_pkg::WDT_RESET;
    end else if (wdt_we) begin
      shared_map_select          <= w_byte[sfr_select_pkg::BIT_MAP_SEL];
      regulator_low_power_enable <= w_byte[sfr_select_pkg::BIT_REG_LP];
      software_watchdog_enable   <= w_byte[sfr_select_pkg::BIT_SW_WDT];
    end
  end

  // Readback with unimplemented bits zero
  always_comb begin
    wdt_value = 8'h00;
    wdt_value[sfr_select_pkg::BIT_REG_LP]  = regulator_low_power_enable;
    wdt_value[sfr_select_pkg::BIT_LV_STAT] = low_voltage_status;
    wdt_value[sfr_select_pkg::BIT_MAP_SEL] = shared_map_select;
    wdt_value[sfr_select_pkg::BIT_SW_WDT]  = software_watchdog_enable;
  end

  // Supply status pin synchroniser
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      supply_meta        <= 1'b0;
      low_voltage_status <= 1'b0;
    end else begin
      supply_meta        <= core_supply_ok;
      low_voltage_status <= supply_meta;
    end
  end

  // =====================================================
  // Parallel port pair routed by port mode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      parallel_port_address     <= 16'h0000;
      parallel_port_output_data <= 16'h0000;
    end else if (parallel_port_master_mode) begin
      parallel_port_address     <= par_pair;
      parallel_port_output_data <= 16'h0000;
    end else begin
      parallel_port_address     <= 16'h0000;
      parallel_port_output_data <= par_pair;
    end
  end

  // =====================================================
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_wdt_write;
    do_write && w_lane0 && dec_wdt;
  endsequence

  sequence s_read_taken;
    arvalid && arready;
  endsequence

  a_select_write_only: assert property (
    $changed(shared_map_select) |-> $past(wdt_we))
    else $error("select bit changed without control write");

  a_select_takes_value: assert property (
    s_wdt_write |=> shared_map_select == $past(w_byte[4]))
    else $error("select bit did not take written value");

  a_reserved_read_zero: assert property (
    do_read && dec_wdt |=> rdata[5] == 1'b0 && rdata[3:1] == 3'h0)
    else $error("unimplemented control bits read nonzero");

  a_unmapped_zero: assert property (
    do_read && !dec_hit && !dec_wdt |=> rdata == 32'h00000000)
    else $error("unmapped location read nonzero");

  a_alt_slot_used: assert property (
    do_write && dec_index == 12'hFD3 && shared_map_select
      |-> dec_slot == 5'h09)
    else $error("shared address missed the alternate slot");

  a_default_slot_used: assert property (
    do_write && dec_index == 12'hFCD && !shared_map_select
      |-> dec_slot == 5'h03)
    else $error("shared address missed the default slot");

  a_small_no_memif: assert property (
    dec_hit && dec_slot == 5'h0E |-> LARGE_VARIANT)
    else $error("memory interface alternate in small variant");

  a_wdt_decode_fixed: assert property (
    dec_index == 12'hFC0 |-> dec_wdt && !dec_hit)
    else $error("control register decode depends on select");

  a_par_same_slot: assert property (
    dec_index == 12'hF47 |-> dec_hit && dec_slot == 5'h16)
    else $error("parallel output pair not on address storage");

  a_serial_mask_mode: assert property (
    dec_index == 12'hFC8 |-> dec_slot == (serial_port_mask_mode[0] ? 5'h13 : 5'h12))
    else $error("serial address or mask chosen wrongly");

  a_read_answer: assert property (
    s_read_taken ##1 !do_write |=> rvalid)
    else $error("read answer missing");

  a_write_answer: assert property (
    do_write |=> bvalid [*1] ##0 bresp == 2'h0)
    else $error("write response missing");

endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
// =====================================================
// Self-checking bench for the shared address register select
module tb;
  // =====================================================
  // Ports, model state and counters
  logic        sys_clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, seed;
  logic [3:0]  wstrb;
  logic [1:0]  serial_port_mask_mode;
  logic        parallel_port_master_mode, core_supply_ok;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        shared_map_select, regulator_low_power_enable, software_watchdog_enable;
  logic [15:0] parallel_port_address, parallel_port_output_data;
  logic [31:0] small_rdata;
  logic [7:0]  mdl [int];
  logic [7:0]  ctl;
  int          fails, checks_done;
  localparam logic [11:0] SH [9] = '{sfr_select_pkg::IDX_OSC_CTRL, sfr_select_pkg::IDX_T1_HIGH,
    sfr_select_pkg::IDX_T1_LOW, sfr_select_pkg::IDX_T1_CTRL, sfr_select_pkg::IDX_T2_COUNT,
    sfr_select_pkg::IDX_T2_PERIOD, sfr_select_pkg::IDX_CONV_0, sfr_select_pkg::IDX_CONV_1,
    sfr_select_pkg::IDX_T4_PERIOD};
  localparam logic [11:0] WDT = sfr_select_pkg::IDX_WDT_CTRL;

  // =====================================================
  // Design under test
  shared_address_sfr_select #(.LARGE_VARIANT(1'b1)) shared_address_sfr_select_i (
    .sys_clk(sys_clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_port_mask_mode(serial_port_mask_mode), .parallel_port_master_mode(parallel_port_master_mode),
    .core_supply_ok(core_supply_ok), .shared_map_select(shared_map_select),
    .regulator_low_power_enable(regulator_low_power_enable),
    .software_watchdog_enable(software_watchdog_enable),
    .parallel_port_address(parallel_port_address), .parallel_port_output_data(parallel_port_output_data));

  // Smaller variant on the same bus, only its read data is compared
  shared_address_sfr_select #(.LARGE_VARIANT(1'b0)) shared_address_sfr_select_small_i (
    .sys_clk(sys_clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(small_rdata), .rresp(), .rvalid(), .rready(rready),
    .serial_port_mask_mode(serial_port_mask_mode), .parallel_port_master_mode(parallel_port_master_mode),
    .core_supply_ok(core_supply_ok), .shared_map_select(), .regulator_low_power_enable(),
    .software_watchdog_enable(), .parallel_port_address(), .parallel_port_output_data());

  // Clock at 125 MHz
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // =====================================================
  // Reporting
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded edge wait, a hang ends the run
  task automatic step(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 64) begin
      fails++;
      report_and_stop();
    end
  endtask

  // =====================================================
  // Stimulus helpers
  function automatic logic [7:0] r8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] mv(input int k);
    return mdl.exists(k) ? mdl[k] : 8'h00;
  endfunction

  // Storage key of an index under the present select and modes, -1 when unmapped
  function automatic int key_of(input logic [11:0] idx);
    foreach (SH[i]) if (idx == SH[i]) return int'(idx) + (ctl[4] ? 4096 : 0);
    if (idx == sfr_select_pkg::IDX_SSP1_ADDR) return int'(idx) + (serial_port_mask_mode[0] ? 4096 : 0);
    if (idx == sfr_select_pkg::IDX_SSP2_ADDR) return int'(idx) + (serial_port_mask_mode[1] ? 4096 : 0);
    if (idx == sfr_select_pkg::IDX_PAR_OUT_H) return int'(sfr_select_pkg::IDX_PAR_ADR_H);
    if (idx == sfr_select_pkg::IDX_PAR_OUT_L) return int'(sfr_select_pkg::IDX_PAR_ADR_L);
    if (idx == sfr_select_pkg::IDX_PAR_ADR_H || idx == sfr_select_pkg::IDX_PAR_ADR_L) return int'(idx);
    return -1;
  endfunction

  // =====================================================
  // Register bus cycles
  task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st);
    int n;
    logic ad, wd;
    logic [31:0] r;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    r = {r8(), r8(), r8(), r8()};
    @(posedge sys_clk);
    awaddr <= {idx, 2'h0};
    wdata <= {r[23:0], d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      step(n);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do step(n); while (!bvalid);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, 32'h0);
  endtask

  task automatic rd(input logic [11:0] idx);
    int n, k;
    logic [31:0] e;
    n = 0;
    k = key_of(idx);
    e = (k < 0) ? 32'h0 : {24'h0, mv(k)};
    if (idx == WDT) e = {24'h0, ctl | {1'b0, core_supply_ok, 6'h0}};
    @(posedge sys_clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (!arready);
    arvalid <= 1'b0;
    do step(n); while (!rvalid);
    rready <= 1'b0;
    check("rdata", rdata, e);
    check("small rdata", small_rdata, (idx == sfr_select_pkg::IDX_T2_PERIOD && ctl[4]) ? 32'h0 : e);
    check("rresp", {30'h0, rresp}, 32'h0);
  endtask

  // Model update then bus write; the select in force is the one before this write
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st);
    int k;
    k = key_of(idx);
    if (st[0] && idx == WDT) ctl = d & 8'h91;
    else if (st[0] && k >= 0) mdl[k] = d;
    axi_wr(idx, d, st);
  endtask

  task automatic outs;
    logic [15:0] p;
    p = {mv(int'(sfr_select_pkg::IDX_PAR_ADR_H)), mv(int'(sfr_select_pkg::IDX_PAR_ADR_L))};
    check("select", {31'h0, shared_map_select}, {31'h0, ctl[4]});
    check("reg_lp", {31'h0, regulator_low_power_enable}, {31'h0, ctl[7]});
    check("wdog", {31'h0, software_watchdog_enable}, {31'h0, ctl[0]});
    check("pp_addr", {16'h0, parallel_port_address}, {16'h0, parallel_port_master_mode ? p : 16'h0});
    check("pp_data", {16'h0, parallel_port_output_data}, {16'h0, parallel_port_master_mode ? 16'h0 : p});
  endtask

  // =====================================================
  // Main sequence
  initial begin
    seed = 32'h726A;
    fails = 0;
    checks_done = 0;
    ctl = 8'h00;
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 14'h0000;
    araddr = 14'h0000;
    wdata = 32'h0;
    wstrb = 4'h0;
    serial_port_mask_mode = 2'h0;
    parallel_port_master_mode = 1'b0;
    core_supply_ok = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(WDT);
    outs();
    wr(WDT, 8'hFF, 4'hF);
    rd(WDT);
    outs();
    // Fill default then alternate side of every shared index
    for (int s = 0; s < 2; s++) begin
      wr(WDT, s[0] ? 8'h10 : 8'h81, 4'hF);
      foreach (SH[i]) wr(SH[i], r8(), 4'hF);
    end
    for (int s = 0; s < 2; s++) begin
      wr(WDT, s[0] ? 8'h11 : 8'h00, 4'hF);
      foreach (SH[i]) rd(SH[i]);
      outs();
    end
    // Serial address or mask by port mode, select has no say
    for (int m = 0; m < 4; m++) begin
      serial_port_mask_mode <= m[1:0];
      @(posedge sys_clk); // Mode settles before the model keys the write
      wr(sfr_select_pkg::IDX_SSP1_ADDR, r8(), 4'hF);
      wr(sfr_select_pkg::IDX_SSP2_ADDR, r8(), 4'hF);
    end
    for (int m = 0; m < 4; m++) begin
      serial_port_mask_mode <= m[1:0];
      wr(WDT, m[0] ? 8'h10 : 8'h00, 4'hF);
      rd(sfr_select_pkg::IDX_SSP1_ADDR);
      rd(sfr_select_pkg::IDX_SSP2_ADDR);
      rd(WDT);
    end
    // Parallel pair is one storage seen through two names
    parallel_port_master_mode <= 1'b1;
    wr(sfr_select_pkg::IDX_PAR_ADR_H, r8(), 4'hF);
    wr(sfr_select_pkg::IDX_PAR_OUT_L, r8(), 4'hF);
    rd(sfr_select_pkg::IDX_PAR_OUT_H);
    rd(sfr_select_pkg::IDX_PAR_ADR_L);
    outs();
    parallel_port_master_mode <= 1'b0;
    repeat (3) @(posedge sys_clk);
    outs();
    // Unimplemented locations and an ignored byte strobe
    wr(12'hFD4, r8(), 4'hF);
    rd(12'hFD4);
    rd(12'h000);
    rd(12'hFC9);
    wr(SH[0], r8(), 4'hE);
    rd(SH[0]);
    // Supply status follows the pin
    core_supply_ok <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(WDT);
    // Second reset in mid-run clears everything
    reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    mdl.delete();
    ctl = 8'h00;
    repeat (3) @(posedge sys_clk);
    rd(WDT);
    rd(SH[2]);
    outs();
    report_and_stop();
  end
endmodule
